// File: rtl/system_reset_exception_control.v
// System reset, recovery counter, interrupt and low-power control
//
// Design decisions made here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "reset_exception_defs.vh"
module system_reset_exception_control #(
    parameter SOURCES = 8,
    parameter INDEX_WIDTH = 3,
    parameter LONG_RECOVERY = `LONG_RECOVERY_CYCLES,
    parameter SHORT_RECOVERY = `SHORT_RECOVERY_CYCLES,
    parameter RELEASE_PHASE = `RELEASE_PHASE_CYCLES
) (
    // Clock and reset; clk_in stands for the selected oscillator clock
    input wire clk_in,
    input wire reset_in,
    // AXI4-Lite slave
    input wire [3:0] s_axi_awaddr_in,
    input wire s_axi_awvalid_in,
    output reg s_axi_awready_out,
    input wire [31:0] s_axi_wdata_in,
    input wire [3:0] s_axi_wstrb_in,
    input wire s_axi_wvalid_in,
    output reg s_axi_wready_out,
    output reg [1:0] s_axi_bresp_out,
    output reg s_axi_bvalid_out,
    input wire s_axi_bready_in,
    input wire [3:0] s_axi_araddr_in,
    input wire s_axi_arvalid_in,
    output reg s_axi_arready_out,
    output reg [31:0] s_axi_rdata_out,
    output reg [1:0] s_axi_rresp_out,
    output reg s_axi_rvalid_out,
    input wire s_axi_rready_in,
    // CPU bus monitoring
    input wire opcode_fetch_in,
    input wire unmapped_addr_in,
    input wire vector_fetch_in,
    input wire [7:0] vector_data_in,
    // Reset and event sources
    input wire low_voltage_in,
    input wire break_in,
    // CPU instruction events
    input wire instr_boundary_in,
    input wire swi_exec_in,
    input wire rti_exec_in,
    input wire wait_exec_in,
    input wire stop_exec_in,
    input wire mask_clear_in,
    input wire [15:0] pc_in,
    // Interrupt sources
    input wire [SOURCES-1:0] irq_request_in,
    input wire [SOURCES-1:0] irq_enable_in,
    // Status flag clear requests from other modules
    input wire flag_clear_req_in,
    // Outputs
    output reg chip_reset_out,
    output reg cpu_reset_out,
    output reg monitor_mode_out,
    output reg cpu_clock_en_out,
    output reg periph_clock_en_out,
    output reg clock_gen_output_en_out,
    output reg watchdog_tick_out,
    output reg watchdog_enable_out,
    output reg interrupt_mask_out,
    output reg stack_start_out,
    output reg [15:0] stacked_pc_out,
    output reg [INDEX_WIDTH:0] vector_select_out,
    output reg break_state_out,
    output reg flag_clear_allow_out
);
    localparam S_RUN = 5'h01;
    localparam S_WAIT = 5'h02;
    localparam S_STOP = 5'h04;
    localparam S_RECOVER = 5'h08;
    localparam S_RELEASE = 5'h10;

    reg [4:0] state;
    reg [`COUNTER_WIDTH-1:0] counter;
    reg [`COUNTER_WIDTH:0] recover_count;
    reg [2:0] reset_cause;
    reg break_flag_clear_enable;
    reg [4:0] config_bits;
    reg latched;
    reg [INDEX_WIDTH-1:0] latched_index;
    reg stop_reset_pending;
    reg write_addr_ok, write_data_ok;
    reg [3:0] write_addr;
    reg [31:0] write_data;

    wire arb_any;
    wire [INDEX_WIDTH-1:0] arb_index;
    wire [SOURCES-1:0] eligible = irq_request_in & irq_enable_in;

    interrupt_arbiter #(.SOURCES(SOURCES), .INDEX_WIDTH(INDEX_WIDTH)) u_interrupt_arbiter (
        .request_in(eligible),
        .any_out(arb_any),
        .index_out(arb_index)
    );

    wire illegal_fetch = opcode_fetch_in & unmapped_addr_in;
    wire erased_vector = vector_fetch_in & (vector_data_in == `ERASED_VECTOR_BYTE);
    wire lv_reset = low_voltage_in & ~config_bits[`CFG_LV_POWER_DISABLE]
        & ~config_bits[`CFG_LV_RESET_DISABLE];
    wire any_reset = illegal_fetch | erased_vector | lv_reset;
    wire hw_take = instr_boundary_in & arb_any & ~interrupt_mask_out;
    wire sw_take = swi_exec_in | break_in;
    wire counter_overflow = (counter == {`COUNTER_WIDTH{1'b1}});

    // Register write path
    wire do_write = write_addr_ok & write_data_ok & ~s_axi_bvalid_out;
    always @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            s_axi_awready_out <= 1'b0;
            s_axi_wready_out <= 1'b0;
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out <= `RESP_OKAY;
            write_addr_ok <= 1'b0;
            write_data_ok <= 1'b0;
            write_addr <= 4'h0;
            write_data <= 32'h00000000;
            break_flag_clear_enable <= 1'b0;
            config_bits <= `CONFIG_RESET;
        end else begin
            s_axi_awready_out <= ~write_addr_ok & ~s_axi_awready_out & s_axi_awvalid_in;
            s_axi_wready_out <= ~write_data_ok & ~s_axi_wready_out & s_axi_wvalid_in;
            if (s_axi_awvalid_in & s_axi_awready_out) begin
                write_addr_ok <= 1'b1;
                write_addr <= s_axi_awaddr_in;
            end
            if (s_axi_wvalid_in & s_axi_wready_out) begin
                write_data_ok <= 1'b1;
                write_data <= s_axi_wdata_in;
            end
            if (do_write) begin
                write_addr_ok <= 1'b0;
                write_data_ok <= 1'b0;
                s_axi_bvalid_out <= 1'b1;
                s_axi_bresp_out <= `RESP_OKAY;
                case (write_addr)
                    `ADDR_BREAK_FLAG_CTRL: begin
                        if (s_axi_wstrb_in[0] | 1'b1)
                            break_flag_clear_enable <= write_data[0];
                    end
                    `ADDR_CONFIG: begin
                        config_bits <= write_data[4:0];
                    end
                    `ADDR_RESET_CAUSE, `ADDR_STATUS: begin
                        s_axi_bresp_out <= `RESP_OKAY;
                    end
                    default: begin
                        s_axi_bresp_out <= `RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_bvalid_out & s_axi_bready_in) begin
                s_axi_bvalid_out <= 1'b0;
            end
        end
    end

    // Register read path; reading the cause register clears it
    wire do_read = s_axi_arvalid_in & s_axi_arready_out;
    always @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out <= 32'h00000000;
            s_axi_rresp_out <= `RESP_OKAY;
        end else begin
            s_axi_arready_out <= ~s_axi_arready_out & ~s_axi_rvalid_out & s_axi_arvalid_in;
            if (do_read) begin
                s_axi_rvalid_out <= 1'b1;
                s_axi_rresp_out <= `RESP_OKAY;
                case (s_axi_araddr_in)
                    `ADDR_RESET_CAUSE: s_axi_rdata_out <= {29'h0, reset_cause};
                    `ADDR_BREAK_FLAG_CTRL: s_axi_rdata_out <= {31'h0, break_flag_clear_enable};
                    `ADDR_CONFIG: s_axi_rdata_out <= {27'h0, config_bits};
                    `ADDR_STATUS: s_axi_rdata_out <= {26'h0, break_state_out, interrupt_mask_out, state[3:0]};
                    default: begin
                        s_axi_rdata_out <= 32'h00000000;
                        s_axi_rresp_out <= `RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid_out & s_axi_rready_in) begin
                s_axi_rvalid_out <= 1'b0;
            end
        end
    end

    // Reset cause flags: a new cause wins over a read clear
    wire cause_read = do_read & (s_axi_araddr_in == `ADDR_RESET_CAUSE);
    always @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            reset_cause <= 3'h0;
        end else if (any_reset) begin
            reset_cause <= {lv_reset, erased_vector, illegal_fetch};
        end else if (cause_read) begin
            reset_cause <= 3'h0;
        end
    end

    // Watchdog prescaler counter, held clear in stop
    always @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            counter <= {`COUNTER_WIDTH{1'b0}};
            watchdog_tick_out <= 1'b0;
        end else begin
            watchdog_tick_out <= counter_overflow & (state != S_STOP);
            if (state == S_STOP || stop_exec_in)
                counter <= {`COUNTER_WIDTH{1'b0}};
            else
                counter <= counter + 1'b1;
        end
    end

    // Main sequencer: resets outrank all interrupt activity
    always @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            state <= S_RECOVER;
            recover_count <= LONG_RECOVERY[`COUNTER_WIDTH:0];
            chip_reset_out <= 1'b1;
            cpu_reset_out <= 1'b1;
            monitor_mode_out <= 1'b0;
            cpu_clock_en_out <= 1'b0;
            periph_clock_en_out <= 1'b0;
            clock_gen_output_en_out <= 1'b1;
            watchdog_enable_out <= 1'b1;
            interrupt_mask_out <= 1'b1;
            stack_start_out <= 1'b0;
            stacked_pc_out <= 16'h0000;
            vector_select_out <= {(INDEX_WIDTH+1){1'b0}};
            latched <= 1'b0;
            latched_index <= {INDEX_WIDTH{1'b0}};
            stop_reset_pending <= 1'b0;
            break_state_out <= 1'b0;
        end else begin
            stack_start_out <= 1'b0;
            watchdog_enable_out <= ~config_bits[`CFG_WATCHDOG_DISABLE];
            if (mask_clear_in)
                interrupt_mask_out <= 1'b0;
            if (rti_exec_in) begin
                latched <= 1'b0;
                break_state_out <= 1'b0;
            end
            if (any_reset) begin
                state <= S_RECOVER;
                recover_count <= LONG_RECOVERY[`COUNTER_WIDTH:0];
                chip_reset_out <= 1'b1;
                cpu_reset_out <= 1'b1;
                cpu_clock_en_out <= 1'b0;
                periph_clock_en_out <= 1'b0;
                clock_gen_output_en_out <= 1'b1;
                interrupt_mask_out <= 1'b1;
                latched <= 1'b0;
                break_state_out <= 1'b0;
                if (erased_vector)
                    monitor_mode_out <= 1'b1;
                stop_reset_pending <= 1'b0;
            end else begin
                case (state)
                    S_RUN: begin
                        if (sw_take) begin
                            stack_start_out <= 1'b1;
                            interrupt_mask_out <= 1'b1;
                            stacked_pc_out <= pc_in;
                            vector_select_out <= {1'b1, {INDEX_WIDTH{1'b0}}};
                            break_state_out <= break_in | break_state_out;
                        end else if (hw_take && !latched) begin
                            latched <= 1'b1;
                            latched_index <= arb_index;
                            stack_start_out <= 1'b1;
                            interrupt_mask_out <= 1'b1;
                            stacked_pc_out <= pc_in - 16'h0001;
                            vector_select_out <= {1'b0, arb_index};
                        end else if (wait_exec_in) begin
                            state <= S_WAIT;
                            interrupt_mask_out <= 1'b0;
                            cpu_clock_en_out <= 1'b0;
                        end else if (stop_exec_in) begin
                            state <= S_STOP;
                            interrupt_mask_out <= 1'b0;
                            cpu_clock_en_out <= 1'b0;
                            periph_clock_en_out <= 1'b0;
                            clock_gen_output_en_out <= config_bits[`CFG_OSC_RUN_IN_STOP];
                        end
                        if (mask_clear_in && !hw_take)
                            latched <= 1'b0;
                    end
                    S_WAIT: begin
                        if (arb_any || break_in) begin
                            state <= S_RUN;
                            cpu_clock_en_out <= 1'b1;
                            stack_start_out <= 1'b1;
                            interrupt_mask_out <= 1'b1;
                            stacked_pc_out <= break_in ? pc_in : pc_in - 16'h0001;
                            vector_select_out <= break_in ? {1'b1, {INDEX_WIDTH{1'b0}}} : {1'b0, arb_index};
                            latched <= ~break_in;
                            latched_index <= arb_index;
                            break_state_out <= break_in;
                        end
                    end
                    S_STOP: begin
                        if (arb_any || break_in) begin
                            state <= S_RECOVER;
                            clock_gen_output_en_out <= 1'b1;
                            recover_count <= config_bits[`CFG_SHORT_STOP_RECOVERY] ?
                                SHORT_RECOVERY[`COUNTER_WIDTH:0] : LONG_RECOVERY[`COUNTER_WIDTH:0];
                            stop_reset_pending <= 1'b1;
                        end
                    end
                    S_RECOVER: begin
                        if (recover_count <= {{`COUNTER_WIDTH{1'b0}}, 1'b1}) begin
                            if (stop_reset_pending) begin
                                state <= S_RUN;
                                stop_reset_pending <= 1'b0;
                                cpu_clock_en_out <= 1'b1;
                                periph_clock_en_out <= 1'b1;
                                stack_start_out <= 1'b1;
                                interrupt_mask_out <= 1'b1;
                                stacked_pc_out <= pc_in - 16'h0001;
                                vector_select_out <= {1'b0, arb_index};
                            end else begin
                                state <= S_RELEASE;
                                chip_reset_out <= 1'b0;
                                periph_clock_en_out <= 1'b1;
                                recover_count <= RELEASE_PHASE[`COUNTER_WIDTH:0];
                            end
                        end else begin
                            recover_count <= recover_count - 1'b1;
                        end
                    end
                    S_RELEASE: begin
                        if (recover_count <= {{`COUNTER_WIDTH{1'b0}}, 1'b1}) begin
                            state <= S_RUN;
                            cpu_reset_out <= 1'b0;
                            cpu_clock_en_out <= 1'b1;
                        end else begin
                            recover_count <= recover_count - 1'b1;
                        end
                    end
                    default: state <= S_RUN;
                endcase
            end
        end
    end

    // Flag clear gating while in break
    always @(posedge clk_in or posedge reset_in) begin
        if (reset_in)
            flag_clear_allow_out <= 1'b0;
        else
            flag_clear_allow_out <= flag_clear_req_in &
                (~break_state_out | break_flag_clear_enable);
    end
endmodule

// File: include/reset_exception_defs.vh
// Constants for the system reset and exception controller
`ifndef RESET_EXCEPTION_DEFS_VH
`define RESET_EXCEPTION_DEFS_VH
// Clock rate and derived figures
`define CLK_FREQ_MHZ 125
`define COUNTER_WIDTH 12
`define LONG_RECOVERY_CYCLES 4096
`define SHORT_RECOVERY_CYCLES 32
`define RELEASE_PHASE_CYCLES 64
`define ERASED_VECTOR_BYTE 8'h00
// Register byte offsets
`define ADDR_RESET_CAUSE 4'h0
`define ADDR_BREAK_FLAG_CTRL 4'h4
`define ADDR_CONFIG 4'h8
`define ADDR_STATUS 4'hC
// Reset cause bit positions
`define CAUSE_ILLEGAL_ADDR 0
`define CAUSE_ERASED_VECTOR 1
`define CAUSE_LOW_VOLTAGE 2
// Config bit positions
`define CFG_LV_POWER_DISABLE 0
`define CFG_LV_RESET_DISABLE 1
`define CFG_SHORT_STOP_RECOVERY 2
`define CFG_OSC_RUN_IN_STOP 3
`define CFG_WATCHDOG_DISABLE 4
`define CONFIG_RESET 5'h00
// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// File: rtl/interrupt_arbiter.v
// Priority arbiter choosing the lowest-numbered enabled request
`timescale 1ns/10ps
module interrupt_arbiter #(
    parameter SOURCES = 8,
    parameter INDEX_WIDTH = 3
) (
    // Requests
    input wire [SOURCES-1:0] request_in,
    // Result
    output reg any_out,
    output reg [INDEX_WIDTH-1:0] index_out
);
    integer i;
    always @* begin
        any_out = 1'b0;
        index_out = {INDEX_WIDTH{1'b0}};
        for (i = SOURCES - 1; i >= 0; i = i - 1) begin
            if (request_in[i]) begin
                any_out = 1'b1;
                index_out = i[INDEX_WIDTH-1:0];
            end
        end
    end
endmodule

// File: testbench/irq_source_model.sv
// Interrupt sources with the service routine that acknowledges them
`timescale 1ns/10ps
module irq_source_model (
    // Clock and reset
    input wire clk_in,
    input wire reset_in,
    // Request control and service acknowledge
    input wire [7:0] raise_in,
    input wire raise_stb_in,
    input wire ack_in,
    input wire [3:0] vector_in,
    // Request levels
    output reg [7:0] irq_out
);
    always @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            irq_out <= 8'h00;
        end else if (raise_stb_in) begin
            irq_out <= raise_in;
        end else if (ack_in && !vector_in[3]) begin
            // Levels stay up until the handler clears the source it serves
            irq_out[vector_in[2:0]] <= 1'b0;
        end
    end
endmodule

// File: testbench/system_reset_exception_control_properties.sv
// Concurrent checks on the reset and exception controller ports
`timescale 1ns/10ps
module system_reset_exception_control_properties #(
    parameter INDEX_WIDTH = 3
) (
    // Clock and reset
    input wire clk_in,
    input wire reset_in,
    // Register bus
    input wire s_axi_bvalid_out,
    input wire s_axi_bready_in,
    input wire [1:0] s_axi_bresp_out,
    input wire s_axi_rvalid_out,
    input wire s_axi_rready_in,
    input wire [31:0] s_axi_rdata_out,
    // CPU side
    input wire opcode_fetch_in,
    input wire unmapped_addr_in,
    input wire swi_exec_in,
    input wire wait_exec_in,
    input wire [15:0] pc_in,
    input wire flag_clear_req_in,
    // Controller outputs
    input wire chip_reset_out,
    input wire cpu_reset_out,
    input wire cpu_clock_en_out,
    input wire periph_clock_en_out,
    input wire watchdog_tick_out,
    input wire interrupt_mask_out,
    input wire stack_start_out,
    input wire [15:0] stacked_pc_out,
    input wire [INDEX_WIDTH:0] vector_select_out,
    input wire flag_clear_allow_out
);
    localparam int RP_MIN = 3;
    localparam int RP_MAX = 6;
    default clocking cb_main @(posedge clk_in);
    endclocking
    default disable iff (reset_in);
    chk_bresp_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
        else $error("write response dropped early");
    chk_rdata_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
        else $error("read data dropped early");
    chk_tick_gap: assert property (watchdog_tick_out |=> !watchdog_tick_out [*8])
        else $error("watchdog ticks too close");
    chk_mask_entry: assert property (stack_start_out |=> interrupt_mask_out)
        else $error("mask not set on service entry");
    chk_swi_entry: assert property (swi_exec_in && cpu_clock_en_out && !cpu_reset_out |=>
        stack_start_out && vector_select_out[INDEX_WIDTH] && stacked_pc_out == $past(pc_in))
        else $error("software interrupt not stacked with current pc");
    chk_release_phase: assert property ($fell(chip_reset_out) |-> ##[RP_MIN:RP_MAX] $fell(cpu_reset_out))
        else $error("cpu release phase wrong");
    chk_illegal_fetch: assert property (opcode_fetch_in && unmapped_addr_in && !chip_reset_out |-> ##[1:3] chip_reset_out)
        else $error("illegal opcode fetch did not reset");
    chk_allow_req: assert property (!flag_clear_req_in |=> !flag_clear_allow_out)
        else $error("flag clear allowed without request");
    chk_wait_clocks: assert property (wait_exec_in && !cpu_reset_out |-> ##[1:2] (!cpu_clock_en_out && periph_clock_en_out))
        else $error("wait clock gating wrong");
    cover property (stack_start_out && !vector_select_out[INDEX_WIDTH]);
    cover property (stack_start_out && vector_select_out[INDEX_WIDTH]);
    cover property ($fell(cpu_reset_out));
endmodule
bind system_reset_exception_control system_reset_exception_control_properties #(.INDEX_WIDTH(INDEX_WIDTH))
    u_props (.*);

// File: testbench/system_reset_exception_control_test.sv
// Self-checking bench for the reset and exception controller
`timescale 1ns/10ps
module system_reset_exception_control_test;
    localparam int LR = 16, SR = 4;
    reg clk_in = 0, reset_in = 1, rstb = 0, low_voltage_in = 0, opcode_fetch_in = 0, unmapped_addr_in = 0;
    reg s_axi_awvalid_in = 0, s_axi_wvalid_in = 0, s_axi_bready_in = 0, s_axi_arvalid_in = 0, s_axi_rready_in = 0;
    reg [3:0] s_axi_awaddr_in = 4'h0, s_axi_araddr_in = 4'h0, s_axi_wstrb_in = 4'hF;
    reg [31:0] s_axi_wdata_in = 32'h0, seed = 32'h1A, t;
    reg vector_fetch_in = 0;
    reg [7:0] vector_data_in = 8'hFF, irq_enable_in = 8'h00, rs = 8'h00, ev = 8'h00, req, left;
    reg [15:0] pc_in = 16'h1234;
    reg [31:0] q[$];
    wire instr_boundary_in = ev[0], swi_exec_in = ev[1], rti_exec_in = ev[2], wait_exec_in = ev[3];
    wire stop_exec_in = ev[4], mask_clear_in = ev[5], break_in = ev[6], flag_clear_req_in = ev[7];
    wire [7:0] irq_request_in;
    wire s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
    wire [1:0] s_axi_bresp_out, s_axi_rresp_out;
    wire [31:0] s_axi_rdata_out;
    wire chip_reset_out, cpu_reset_out, monitor_mode_out, cpu_clock_en_out, periph_clock_en_out, break_state_out;
    wire clock_gen_output_en_out, watchdog_tick_out, watchdog_enable_out, interrupt_mask_out, stack_start_out;
    wire flag_clear_allow_out;
    wire [15:0] stacked_pc_out;
    wire [3:0] vector_select_out;
    int failures = 0, num_checks = 0, a, b, n;
    always #4 clk_in = ~clk_in;
    system_reset_exception_control #(.LONG_RECOVERY(LR), .SHORT_RECOVERY(SR), .RELEASE_PHASE(4))
        u_system_reset_exception_control (.*);
    irq_source_model u_irq_source_model (.clk_in(clk_in), .reset_in(reset_in), .raise_in(rs), .raise_stb_in(rstb),
        .ack_in(stack_start_out), .vector_in(vector_select_out), .irq_out(irq_request_in));
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task chk(input [31:0] s, input [31:0] e);
        num_checks++;
        if (s !== e) begin
            failures++;
            $display("BAD %0t got %h want %h", $time, s, e);
        end
    endtask
    task take(input [31:0] v);
        chk(v, q.size() ? q.pop_front() : ~v);
    endtask
    // Oldest expectation against each read answer, or against a service entry in a cycle without a read answer
    always @(posedge clk_in) begin
        if (s_axi_rvalid_out && s_axi_rready_in) take(s_axi_rdata_out);
        else if (stack_start_out === 1'b1) take({12'h000, vector_select_out[3] ? 4'h8 : vector_select_out, stacked_pc_out});
    end
    task pulse(input [7:0] m);
        @(posedge clk_in) ev <= m;
        @(posedge clk_in) ev <= 8'h00;
    endtask
    task raise(input [7:0] m);
        @(posedge clk_in) begin
            rs <= m;
            rstb <= 1'b1;
        end
        @(posedge clk_in) rstb <= 1'b0;
    endtask
    task settle;
        repeat (2) @(posedge clk_in);
        #1;
    endtask
    task stk(output int k);
        for (k = 0; stack_start_out !== 1'b1 && k < 5000; k++) @(posedge clk_in);
    endtask
    task up(output int ca, output int cb);
        for (ca = 0; chip_reset_out !== 1'b1 && ca < 10; ca++) @(posedge clk_in);
        for (ca = 0; chip_reset_out === 1'b1 && ca < 9999; ca++) @(posedge clk_in);
        for (cb = 0; cpu_reset_out === 1'b1 && cb < 9999; cb++) @(posedge clk_in);
    endtask
    task wr(input [3:0] ad, input [31:0] d);
        @(posedge clk_in) begin
            s_axi_awaddr_in <= ad;
            s_axi_wdata_in <= d;
            s_axi_awvalid_in <= 1'b1;
            s_axi_wvalid_in <= 1'b1;
            s_axi_bready_in <= 1'b1;
        end
        do begin
            @(posedge clk_in);
            if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
            if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
        end while (s_axi_bvalid_out !== 1'b1);
        s_axi_bready_in <= 1'b0;
        chk(s_axi_bresp_out, 0);
    endtask
    task rd(input [3:0] ad, input [31:0] e);
        q.push_back(e);
        @(posedge clk_in) begin
            s_axi_araddr_in <= ad;
            s_axi_arvalid_in <= 1'b1;
            s_axi_rready_in <= 1'b1;
        end
        do begin
            @(posedge clk_in);
            if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
        end while (s_axi_rvalid_out !== 1'b1);
        s_axi_rready_in <= 1'b0;
        chk(s_axi_rresp_out, ad[1:0] ? 2 : 0);
    endtask
    task print_verdict;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #300000;
        failures++;
        print_verdict;
    end
    initial begin
        repeat (4) @(posedge clk_in);
        reset_in <= 1'b0;
        up(a, b);
        chk(a >= LR && a <= LR + 3, 1);
        chk(b >= 3 && b <= 6, 1);
        wr(4'h8, 32'h10);
        settle;
        chk(watchdog_enable_out, 0);
        rd(4'h8, 32'h10);
        rd(4'h2, 32'h0);
        wr(4'h8, 32'h0);
        pulse(8'h20);
        // Random pending sets served one by one in priority order
        for (int r = 0; r < 3; r++) begin
            t = rnd();
            req = t[7:0] | 8'h10;
            left = req & (t[15:8] | 8'h10);
            irq_enable_in <= t[15:8] | 8'h10;
            raise(req);
            for (int i = 0; i < 8; i++) begin
                if (left[i]) begin
                    t = rnd();
                    pc_in <= t[15:0];
                    q.push_back({12'h000, 1'b0, i[2:0], t[15:0] - 16'h0001});
                    pulse(8'h01);
                    stk(n);
                    pulse(8'h01);
                    if (i == 4) begin
                        q.push_back({12'h000, 4'h8, t[15:0]});
                        pulse(8'h02);
                        stk(n);
                        pulse(8'h04);
                    end
                    pulse(8'h24);
                end
            end
            raise(8'h00);
        end
        irq_enable_in <= 8'hFF;
        pulse(8'h08);
        settle;
        chk(interrupt_mask_out, 0);
        chk({cpu_clock_en_out, periph_clock_en_out, watchdog_enable_out}, 3'h3);
        q.push_back({12'h000, 4'h3, pc_in - 16'h0001});
        raise(8'h08);
        stk(n);
        chk(n <= 4, 1);
        raise(8'h00);
        pulse(8'h24);
        for (int s = 0; s < 2; s++) begin
            wr(4'h8, s ? 32'h4 : 32'h0);
            pulse(8'h10);
            settle;
            chk({cpu_clock_en_out, periph_clock_en_out, clock_gen_output_en_out}, 0);
            q.push_back({12'h000, 4'h1, pc_in - 16'h0001});
            raise(8'h02);
            stk(n);
            chk(s ? n <= SR + 4 : n >= LR, 1);
            raise(8'h00);
            pulse(8'h24);
            settle;
        end
        q.push_back({12'h000, 4'h8, pc_in});
        pulse(8'h40);
        stk(n);
        for (int e = 0; e < 2; e++) begin
            wr(4'h4, e ? 32'h1 : 32'h0);
            pulse(8'h80);
            #1;
            chk(flag_clear_allow_out, e);
        end
        wr(4'h4, 32'h0);
        chk(break_state_out, 1);
        pulse(8'h24);
        settle;
        chk(break_state_out, 0);
        pulse(8'h80);
        #1;
        chk(flag_clear_allow_out, 1);
        @(posedge clk_in) unmapped_addr_in <= 1'b1;
        settle;
        chk(chip_reset_out, 0);
        @(posedge clk_in) opcode_fetch_in <= 1'b1;
        @(posedge clk_in) opcode_fetch_in <= 1'b0;
        unmapped_addr_in <= 1'b0;
        up(a, b);
        rd(4'h0, 32'h1);
        for (int v = 0; v < 2; v++) begin
            @(posedge clk_in) vector_fetch_in <= 1'b1;
            vector_data_in <= v ? 8'h00 : 8'h5A;
            @(posedge clk_in) vector_fetch_in <= 1'b0;
            settle;
            chk(chip_reset_out, v);
        end
        up(a, b);
        chk(monitor_mode_out, 1);
        rd(4'h0, 32'h2);
        for (int c = 0; c < 3; c++) begin
            wr(4'h8, c == 2 ? 32'h0 : 32'(c + 1));
            @(posedge clk_in) low_voltage_in <= 1'b1;
            settle;
            chk(chip_reset_out, c == 2);
            @(posedge clk_in) low_voltage_in <= 1'b0;
        end
        up(a, b);
        chk(a >= LR && a <= LR + 3, 1);
        rd(4'h0, 32'h4);
        for (n = 0; watchdog_tick_out !== 1'b1 && n < 5000; n++) @(posedge clk_in);
        chk(watchdog_tick_out, 1);
        chk(q.size(), 0);
        print_verdict;
    end
endmodule
